// *** logic/smrc_cfg.svh ***
`ifndef SMRC_CFG_SVH
`define SMRC_CFG_SVH

// operating setup register layout
`define SMRC_SETUP_W        24
`define SMRC_SETUP_RESET    24'h000000
`define SMRC_UPPER_HI       23
`define SMRC_UPPER_LO       12
`define SMRC_RUN_BIT        11
`define SMRC_POLL_BIT       10
`define SMRC_CRC_BIT        9
`define SMRC_ACT_HI         8
`define SMRC_ACT_LO         5
`define SMRC_PER_HI         4
`define SMRC_PER_LO         1
`define SMRC_RESET_BIT      0
`define SMRC_CODE_W         4
`define SMRC_CODE_MAX       4'hC

// exempt comparator setup register
`define SMRC_EXEMPT_W       24
`define SMRC_EXEMPT_RESET   24'h000000

// timing: clock rate and units
`define SMRC_CLK_HZ         20000000
`define SMRC_HZ_PER_MHZ     1000000
`define SMRC_US_PER_MS      1000

// sample-on duration table in microseconds, codes 0h..Ch, and the default above Ch
`define SMRC_ACT_US_W       12
`define SMRC_ACT_US_TABLE   '{12'h040, 12'h080, 12'h0C0, 12'h100, 12'h140, 12'h180, 12'h1BC, \
                              12'h200, 12'h280, 12'h300, 12'h380, 12'h400, 12'h7FC}
`define SMRC_ACT_US_DEF     12'h200

// polling period table in milliseconds, codes 0h..Ch, and the default above Ch
`define SMRC_PER_MS_W       13
`define SMRC_PER_MS_TABLE   '{13'h0002, 13'h0004, 13'h0008, 13'h0010, 13'h0020, 13'h0030, \
                              13'h0040, 13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800, \
                              13'h1000}
`define SMRC_PER_MS_DEF     13'h0008

// checksum engine
`define SMRC_CRC_W          8
`define SMRC_CRC_POLY       8'h07
`define SMRC_CRC_INIT       8'hFF

`endif

// *** logic/smrc_pkg.sv ***
package smrc_pkg;

    typedef enum logic [1:0] {
        POLL_IDLE   = 2'b00,
        POLL_ACTIVE = 2'b01,
        POLL_WAIT   = 2'b10
    } smrc_poll_e;

    typedef enum logic [0:0] {
        CRC_IDLE  = 1'b0,
        CRC_SHIFT = 1'b1
    } smrc_crc_e;

endpackage

// *** logic/smrc_poll_timer.sv ***
`timescale 1ns/1ps
`include "smrc_cfg.svh"

module smrc_poll_timer #(
    parameter int CYC_PER_US = `SMRC_CLK_HZ / `SMRC_HZ_PER_MHZ,
    parameter int US_PER_MS  = `SMRC_US_PER_MS
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic                    softReset,
    input  wire logic                    run,
    input  wire logic                    pollMode,
    input  wire logic [`SMRC_CODE_W-1:0] actCode,
    input  wire logic [`SMRC_CODE_W-1:0] perCode,
    output logic                         wettingOn,
    output logic                         sampleStrobe,
    output smrc_pkg::smrc_poll_e         pollState
);
    localparam logic [`SMRC_ACT_US_W-1:0] ACT_TABLE [13] = `SMRC_ACT_US_TABLE;
    localparam logic [`SMRC_PER_MS_W-1:0] PER_TABLE [13] = `SMRC_PER_MS_TABLE;
    localparam int DIV_W = $clog2(CYC_PER_US + 1);
    localparam logic [DIV_W-1:0] DIV_END = DIV_W'(CYC_PER_US - 1);

    function automatic logic [`SMRC_ACT_US_W-1:0] actUs(input logic [`SMRC_CODE_W-1:0] c);
        if (c > `SMRC_CODE_MAX) begin
            actUs = `SMRC_ACT_US_DEF;
        end else begin
            actUs = ACT_TABLE[c];
        end
    endfunction

    function automatic logic [`SMRC_PER_MS_W-1:0] perMs(input logic [`SMRC_CODE_W-1:0] c);
        if (c > `SMRC_CODE_MAX) begin
            perMs = `SMRC_PER_MS_DEF;
        end else begin
            perMs = PER_TABLE[c];
        end
    endfunction

    logic [DIV_W-1:0]       usDiv;
    logic [DIV_W-1:0]       next_usDiv;
    logic [31:0]            cycUs;
    logic [31:0]            next_cycUs;
    smrc_pkg::smrc_poll_e   next_pollState;
    logic                   next_sampleStrobe;
    logic                   usTick;
    logic [31:0]            actEnd;
    logic [31:0]            perEnd;

    always_comb begin
        usTick = (usDiv == DIV_END);
        actEnd = 32'(actUs(actCode)) - 32'h1;
        perEnd = 32'(perMs(perCode)) * 32'(US_PER_MS) - 32'h1;
        next_usDiv = usTick ? '0 : usDiv + DIV_W'(1);
        next_cycUs = cycUs;
        next_pollState = pollState;
        next_sampleStrobe = 1'b0;
        case (pollState)
            smrc_pkg::POLL_IDLE: begin
                next_usDiv = '0;
                next_cycUs = '0;
                if (run) begin
                    next_pollState = smrc_pkg::POLL_ACTIVE;
                end
            end
            smrc_pkg::POLL_ACTIVE: begin
                if (usTick) begin
                    next_cycUs = cycUs + 32'h1;
                    if (cycUs == actEnd || cycUs == perEnd) begin
                        next_sampleStrobe = 1'b1;
                        next_pollState = smrc_pkg::POLL_WAIT;
                    end
                    if (cycUs == perEnd) begin
                        next_cycUs = '0;
                        next_pollState = smrc_pkg::POLL_ACTIVE;
                    end
                end
            end
            smrc_pkg::POLL_WAIT: begin
                if (usTick) begin
                    next_cycUs = cycUs + 32'h1;
                    if (cycUs >= perEnd) begin
                        next_cycUs = '0;
                        next_pollState = smrc_pkg::POLL_ACTIVE;
                    end
                end
            end
            default: next_pollState = smrc_pkg::POLL_IDLE;
        endcase
        if (!run || softReset) begin
            next_pollState = smrc_pkg::POLL_IDLE;
            next_sampleStrobe = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            usDiv <= '0;
            cycUs <= '0;
            pollState <= smrc_pkg::POLL_IDLE;
            sampleStrobe <= 1'b0;
        end else if (ce) begin
            usDiv <= next_usDiv;
            cycUs <= next_cycUs;
            pollState <= next_pollState;
            sampleStrobe <= next_sampleStrobe;
        end
    end

    // continuous mode keeps the current on between samples
    assign wettingOn = (pollState == smrc_pkg::POLL_ACTIVE) ||
                       (pollState == smrc_pkg::POLL_WAIT && !pollMode);
endmodule

// *** logic/smrc_crc.sv ***
`timescale 1ns/1ps
`include "smrc_cfg.svh"

module smrc_crc #(
    parameter int DATA_W = `SMRC_SETUP_W + `SMRC_EXEMPT_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   abort,
    input  wire logic                   start,
    input  wire logic [DATA_W-1:0]      data,
    output logic                        busy,
    output logic                        done,
    output logic [`SMRC_CRC_W-1:0]      result
);
    localparam int CNT_W = $clog2(DATA_W + 1);

    smrc_pkg::smrc_crc_e        state;
    smrc_pkg::smrc_crc_e        next_state;
    logic [DATA_W-1:0]          shreg;
    logic [DATA_W-1:0]          next_shreg;
    logic [CNT_W-1:0]           cnt;
    logic [CNT_W-1:0]           next_cnt;
    logic [`SMRC_CRC_W-1:0]     crc;
    logic [`SMRC_CRC_W-1:0]     next_crc;
    logic [`SMRC_CRC_W-1:0]     next_result;
    logic                       next_done;
    logic                       fb;

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_cnt = cnt;
        next_crc = crc;
        next_result = result;
        next_done = 1'b0;
        fb = crc[`SMRC_CRC_W-1] ^ shreg[DATA_W-1];
        case (state)
            smrc_pkg::CRC_IDLE: begin
                if (start) begin
                    next_shreg = data;
                    next_cnt = '0;
                    next_crc = `SMRC_CRC_INIT;
                    next_state = smrc_pkg::CRC_SHIFT;
                end
            end
            smrc_pkg::CRC_SHIFT: begin
                next_crc = {crc[`SMRC_CRC_W-2:0], 1'b0} ^ (fb ? `SMRC_CRC_POLY : '0);
                next_shreg = {shreg[DATA_W-2:0], 1'b0};
                next_cnt = cnt + CNT_W'(1);
                if (cnt == CNT_W'(DATA_W - 1)) begin
                    next_result = next_crc;
                    next_done = 1'b1;
                    next_state = smrc_pkg::CRC_IDLE;
                end
            end
            default: next_state = smrc_pkg::CRC_IDLE;
        endcase
        if (abort) begin
            next_state = smrc_pkg::CRC_IDLE;
            next_done = 1'b0;
            next_result = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= smrc_pkg::CRC_IDLE;
            shreg <= '0;
            cnt <= '0;
            crc <= '0;
            result <= '0;
            done <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            shreg <= next_shreg;
            cnt <= next_cnt;
            crc <= next_crc;
            result <= next_result;
            done <= next_done;
        end
    end

    assign busy = (state == smrc_pkg::CRC_SHIFT);
endmodule

// *** logic/smrc_run_control.sv ***
// Notes on behaviour
// - run bit set starts wetting and polling
// - run bit cleared halts, stays idle
// - run, checksum start, comparator setup writable running
// - mode bit: zero continuous, one polling
// - checksum start computes CRC over configuration
// - checksum finish sets flag, interrupt low
// - checksum start bit self-clears after computation
// - sample-on duration code selects active time
// - period code selects polling period
// - writing one to bit zero resets
`timescale 1ns/1ps
`include "smrc_cfg.svh"

module smrc_run_control #(
    parameter int CYC_PER_US = `SMRC_CLK_HZ / `SMRC_HZ_PER_MHZ,
    parameter int US_PER_MS  = `SMRC_US_PER_MS
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      setupWrite,
    input  wire logic [`SMRC_SETUP_W-1:0]  setupWdata,
    output logic      [`SMRC_SETUP_W-1:0]  setupRdata,
    input  wire logic                      exemptWrite,
    input  wire logic [`SMRC_EXEMPT_W-1:0] exemptWdata,
    output logic      [`SMRC_EXEMPT_W-1:0] exemptComparatorSetup,
    input  wire logic                      flagClear,
    output logic                           checksumDoneFlag,
    output logic                           intN,
    output logic      [`SMRC_CRC_W-1:0]    checksumResult,
    output logic                           checksumBusy,
    output logic                           running,
    output logic                           pollMode,
    output logic [`SMRC_CODE_W-1:0]        sampleOnDuration,
    output logic [`SMRC_CODE_W-1:0]        pollPeriodCode,
    output logic [`SMRC_UPPER_HI-`SMRC_UPPER_LO:0] upperSetup,
    output logic                           wettingOn,
    output logic                           sampleStrobe,
    output logic                           softResetPulse,
    output logic                           reconfigWhileRunning
);
    logic [`SMRC_SETUP_W-1:0]  setup;
    logic [`SMRC_SETUP_W-1:0]  next_setup;
    logic [`SMRC_EXEMPT_W-1:0] next_exempt;
    logic                      next_flag;
    logic                      next_softResetPulse;
    logic                      next_reconfig;
    logic                      crcStartPending;
    logic                      crcLaunch;
    logic                      crcDone;
    logic                      resetReq;
    logic                      launched;
    logic                      next_launched;
    logic [`SMRC_SETUP_W-1:0]  protectedMask;
    smrc_pkg::smrc_poll_e      pollState;

    // bits whose change while running is noted; run, checksum start and reset bits are exempt
    always_comb begin
        protectedMask = '1;
        protectedMask[`SMRC_RUN_BIT] = 1'b0;
        protectedMask[`SMRC_CRC_BIT] = 1'b0;
        protectedMask[`SMRC_RESET_BIT] = 1'b0;
    end

    assign resetReq = setupWrite && setupWdata[`SMRC_RESET_BIT];

    // operating setup register
    always_comb begin
        next_setup = setup;
        next_reconfig = reconfigWhileRunning;
        // a change noted in the clear cycle wins over the clear
        if (flagClear) begin
            next_reconfig = 1'b0;
        end
        if (crcDone) begin
            next_setup[`SMRC_CRC_BIT] = 1'b0;
        end
        if (setupWrite) begin
            next_setup = setupWdata;
            next_setup[`SMRC_RESET_BIT] = 1'b0;
            // a pending start is not cleared by a write, other than a soft reset write, before its completion edge
            if (setup[`SMRC_CRC_BIT] && !crcDone) begin
                next_setup[`SMRC_CRC_BIT] = 1'b1;
            end
            if (setup[`SMRC_RUN_BIT] &&
                ((setupWdata ^ setup) & protectedMask) != '0) begin
                next_reconfig = 1'b1;
            end
        end
        if (resetReq) begin
            next_setup = `SMRC_SETUP_RESET;
            next_reconfig = 1'b0;
        end
    end

    // exempt comparator setup register
    always_comb begin
        next_exempt = exemptComparatorSetup;
        if (exemptWrite) begin
            next_exempt = exemptWdata;
        end
        if (resetReq) begin
            next_exempt = `SMRC_EXEMPT_RESET;
        end
    end

    // checksum launch and done flag
    assign crcStartPending = setup[`SMRC_CRC_BIT];
    assign crcLaunch = crcStartPending && !launched && !checksumBusy;

    always_comb begin
        next_launched = launched;
        if (crcLaunch) begin
            next_launched = 1'b1;
        end
        if (crcDone || !crcStartPending) begin
            next_launched = 1'b0;
        end
        next_flag = checksumDoneFlag;
        if (flagClear) begin
            next_flag = 1'b0;
        end
        if (crcDone) begin
            next_flag = 1'b1;
        end
        next_softResetPulse = resetReq;
        if (resetReq) begin
            next_flag = 1'b0;
            next_launched = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setup <= `SMRC_SETUP_RESET;
            exemptComparatorSetup <= `SMRC_EXEMPT_RESET;
            checksumDoneFlag <= 1'b0;
            softResetPulse <= 1'b0;
            reconfigWhileRunning <= 1'b0;
            launched <= 1'b0;
        end else if (ce) begin
            setup <= next_setup;
            exemptComparatorSetup <= next_exempt;
            checksumDoneFlag <= next_flag;
            softResetPulse <= next_softResetPulse;
            reconfigWhileRunning <= next_reconfig;
            launched <= next_launched;
        end
    end

    smrc_crc #(
        .DATA_W (`SMRC_SETUP_W + `SMRC_EXEMPT_W)
    ) u_crc (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .abort  (resetReq),
        .start  (crcLaunch),
        .data   ({exemptComparatorSetup, setup & protectedMask | (setup & ~protectedMask &
                  {{(`SMRC_SETUP_W-`SMRC_RUN_BIT-1){1'b0}}, 1'b1, {`SMRC_RUN_BIT{1'b0}}})}),
        .busy   (checksumBusy),
        .done   (crcDone),
        .result (checksumResult)
    );

    smrc_poll_timer #(
        .CYC_PER_US (CYC_PER_US),
        .US_PER_MS  (US_PER_MS)
    ) u_timer (
        .clk          (clk),
        .rst          (rst),
        .ce           (ce),
        .softReset    (resetReq),
        .run          (setup[`SMRC_RUN_BIT]),
        .pollMode     (setup[`SMRC_POLL_BIT]),
        .actCode      (setup[`SMRC_ACT_HI:`SMRC_ACT_LO]),
        .perCode      (setup[`SMRC_PER_HI:`SMRC_PER_LO]),
        .wettingOn    (wettingOn),
        .sampleStrobe (sampleStrobe),
        .pollState    (pollState)
    );

    assign setupRdata = setup;
    assign running = (pollState != smrc_pkg::POLL_IDLE);
    assign pollMode = setup[`SMRC_POLL_BIT];
    assign sampleOnDuration = setup[`SMRC_ACT_HI:`SMRC_ACT_LO];
    assign pollPeriodCode = setup[`SMRC_PER_HI:`SMRC_PER_LO];
    assign upperSetup = setup[`SMRC_UPPER_HI:`SMRC_UPPER_LO];
    assign intN = ~checksumDoneFlag;
endmodule

// *** tb/smrc_run_control_chk.sv ***
`timescale 1ns/1ps
`include "smrc_cfg.svh"

module smrc_run_control_chk (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      setupWrite,
    input  wire logic [`SMRC_SETUP_W-1:0]  setupWdata,
    input  wire logic [`SMRC_SETUP_W-1:0]  setupRdata,
    input  wire logic                      exemptWrite,
    input  wire logic [`SMRC_EXEMPT_W-1:0] exemptWdata,
    input  wire logic [`SMRC_EXEMPT_W-1:0] exemptComparatorSetup,
    input  wire logic                      flagClear,
    input  wire logic                      checksumDoneFlag,
    input  wire logic                      intN,
    input  wire logic                      checksumBusy,
    input  wire logic                      running,
    input  wire logic                      pollMode,
    input  wire logic [`SMRC_CODE_W-1:0]   sampleOnDuration,
    input  wire logic [`SMRC_CODE_W-1:0]   pollPeriodCode,
    input  wire logic                      wettingOn,
    input  wire logic                      sampleStrobe,
    input  wire logic                      softResetPulse,
    input  wire logic                      reconfigWhileRunning
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic takeW;
    logic rstW;
    logic cfgDiff;
    assign takeW   = ce && setupWrite;
    assign rstW    = takeW && setupWdata[0];
    // non-exempt fields only: run and checksum start may change while running
    assign cfgDiff = {setupWdata[23:12], setupWdata[10], setupWdata[8:1]}
                  != {setupRdata[23:12], setupRdata[10], setupRdata[8:1]};

    a_intn_mirror: assert property (intN == !checksumDoneFlag)
        else $error("interrupt pin does not mirror the done flag");
    a_soft_reset: assert property (rstW |=> setupRdata == 24'h000000 && softResetPulse
        && exemptComparatorSetup == 24'h000000 && !checksumDoneFlag)
        else $error("reset write did not clear the settings");
    a_bit0_zero: assert property (!setupRdata[0])
        else $error("reset bit read back as one");
    a_run_start: assert property ((takeW && setupWdata[11] && !setupWdata[0]) ##1 ce |=> running)
        else $error("run bit did not start operation");
    a_run_stop: assert property (ce && !setupRdata[11] |=> !running)
        else $error("operation continued with run bit clear");
    a_cont_wet: assert property (running && !pollMode && $stable(pollMode) |-> wettingOn)
        else $error("continuous mode without wetting current");
    a_field_decode: assert property (pollMode == setupRdata[10]
        && sampleOnDuration == setupRdata[8:5] && pollPeriodCode == setupRdata[4:1])
        else $error("mode or code outputs differ from the register");
    a_strobe_pulse: assert property (sampleStrobe && ce |=> !sampleStrobe)
        else $error("sample strobe longer than one cycle");
    a_crc_finish: assert property (disable iff (rst || rstW)
        $rose(checksumBusy) |-> checksumBusy[*8] ##[38:42]
        (checksumDoneFlag && !setupRdata[9] && !checksumBusy))
        else $error("checksum did not finish on time or start bit stayed set");
    a_flag_hold: assert property (checksumDoneFlag && ce && !flagClear && !rstW
        |=> checksumDoneFlag)
        else $error("done flag dropped without a clear");
    a_exempt_wr: assert property (ce && exemptWrite && !rstW
        |=> exemptComparatorSetup == $past(exemptWdata))
        else $error("comparator setup write lost");
    a_reconfig: assert property (takeW && setupRdata[11] && !setupWdata[0] && cfgDiff
        |=> reconfigWhileRunning)
        else $error("setting change while running not noted");

    c_crc_done: cover property ($rose(checksumDoneFlag));
    c_poll_strobe: cover property (sampleStrobe && pollMode);
    c_soft_reset: cover property (softResetPulse);
    c_reconfig: cover property ($rose(reconfigWhileRunning));
endmodule

bind smrc_run_control smrc_run_control_chk chk (.clk, .rst, .ce, .setupWrite, .setupWdata,
    .setupRdata, .exemptWrite, .exemptWdata, .exemptComparatorSetup, .flagClear,
    .checksumDoneFlag, .intN, .checksumBusy, .running, .pollMode, .sampleOnDuration,
    .pollPeriodCode, .wettingOn, .sampleStrobe, .softResetPulse, .reconfigWhileRunning);

// *** tb/smrc_host_model.sv ***
`timescale 1ns/1ps
`include "smrc_cfg.svh"

module smrc_host_model (
    input  wire logic                      clk,
    output logic                           setupWrite,
    output logic [`SMRC_SETUP_W-1:0]       setupWdata,
    output logic                           exemptWrite,
    output logic [`SMRC_EXEMPT_W-1:0]      exemptWdata,
    output logic                           flagClear
);
    initial begin
        setupWrite = 1'b0;
        setupWdata = 24'h000000;
        exemptWrite = 1'b0;
        exemptWdata = 24'h000000;
        flagClear = 1'b0;
    end

    // released data is inverted so a stale value is never mistaken for a write
    task automatic wrSetup(input logic [`SMRC_SETUP_W-1:0] d);
        @(posedge clk);
        setupWrite <= 1'b1;
        setupWdata <= d;
        @(posedge clk);
        setupWrite <= 1'b0;
        setupWdata <= ~d;
    endtask

    task automatic wrExempt(input logic [`SMRC_EXEMPT_W-1:0] d);
        @(posedge clk);
        exemptWrite <= 1'b1;
        exemptWdata <= d;
        @(posedge clk);
        exemptWrite <= 1'b0;
        exemptWdata <= ~d;
    endtask

    task automatic clearFlag();
        @(posedge clk);
        flagClear <= 1'b1;
        @(posedge clk);
        flagClear <= 1'b0;
    endtask
endmodule

// *** tb/smrc_tb.sv ***
`timescale 1ns/1ps
`include "smrc_cfg.svh"

module tb;
    localparam int CPU = 2;
    localparam int UPM = 4;
    logic        clk, rst, ce, setupWrite, exemptWrite, flagClear;
    logic [23:0] setupWdata, exemptWdata, setupRdata, exemptComparatorSetup;
    logic        checksumDoneFlag, intN, checksumBusy, running, pollMode, wettingOn;
    logic        sampleStrobe, softResetPulse, reconfigWhileRunning;
    logic [7:0]  checksumResult;
    logic [3:0]  sampleOnDuration, pollPeriodCode;
    logic [11:0] upperSetup;
    int          nErrors, compares, per, wet, expPer, expWet;
    logic [3:0]  actC [5] = '{4'h0, 4'h6, 4'hD, 4'h0, 4'h0};
    logic [3:0]  perC [5] = '{4'h4, 4'h8, 4'h8, 4'hF, 4'h4};
    int          actUs [5] = '{64, 444, 512, 64, 64};
    int          perMs [5] = '{32, 256, 256, 8, 32};
    logic        pollB [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    smrc_run_control #(.CYC_PER_US(CPU), .US_PER_MS(UPM)) dut (
        .clk                   (clk),
        .rst                   (rst),
        .ce                    (ce),
        .setupWrite            (setupWrite),
        .setupWdata            (setupWdata),
        .setupRdata            (setupRdata),
        .exemptWrite           (exemptWrite),
        .exemptWdata           (exemptWdata),
        .exemptComparatorSetup (exemptComparatorSetup),
        .flagClear             (flagClear),
        .checksumDoneFlag      (checksumDoneFlag),
        .intN                  (intN),
        .checksumResult        (checksumResult),
        .checksumBusy          (checksumBusy),
        .running               (running),
        .pollMode              (pollMode),
        .sampleOnDuration      (sampleOnDuration),
        .pollPeriodCode        (pollPeriodCode),
        .upperSetup            (upperSetup),
        .wettingOn             (wettingOn),
        .sampleStrobe          (sampleStrobe),
        .softResetPulse        (softResetPulse),
        .reconfigWhileRunning  (reconfigWhileRunning)
    );

    smrc_host_model host (
        .clk         (clk),
        .setupWrite  (setupWrite),
        .setupWdata  (setupWdata),
        .exemptWrite (exemptWrite),
        .exemptWdata (exemptWdata),
        .flagClear   (flagClear)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic summarize();
        $display("errors=%0d compares=%0d", nErrors, compares);
        if (nErrors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t %s seen=%0h exp=%0h", $time, what, seen, exp);
        end
    endtask

    task automatic waitHigh(ref logic s, input int lim);
        int i;
        i = 0;
        while (s !== 1'b1) begin
            @(posedge clk);
            #1;
            i++;
            if (i > lim) begin
                nErrors++;
                $display("MISMATCH t=%0t wait ran out", $time);
                summarize();
            end
        end
    endtask

    function automatic logic [7:0] crc8(input logic [47:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 47; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    initial begin
        nErrors = 0;
        compares = 0;
        rst = 1'b1;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(setupRdata, 24'h000000, "setup after reset");
        check(intN, 1'b1, "intN idle");
        for (int i = 0; i < 5; i++) begin
            expPer = perMs[i] * UPM * CPU;
            expWet = (actUs[i] * CPU < expPer && pollB[i]) ? actUs[i] * CPU : expPer;
            // settings changed only while stopped
            host.wrSetup({13'h0000, pollB[i], 1'b0, actC[i], perC[i], 1'b0});
            host.wrSetup({12'h000, 1'b1, pollB[i], 1'b0, actC[i], perC[i], 1'b0});
            repeat (2) @(posedge clk);
            #1;
            check(running, 1'b1, "running after start");
            waitHigh(sampleStrobe, 5000);
            per = 0;
            wet = 0;
            do begin
                @(posedge clk);
                #1;
                per++;
                if (wettingOn === 1'b1) wet++;
            end while (sampleStrobe !== 1'b1 && per < 5000);
            check(per, expPer, "poll period");
            check(wet, expWet, "wetting time");
            host.wrSetup({13'h0000, pollB[i], 1'b0, actC[i], perC[i], 1'b0});
            repeat (2) @(posedge clk);
            #1;
            check(running, 1'b0, "halted");
            check(wettingOn, 1'b0, "no wetting when halted");
        end
        host.wrSetup(24'h5A3008);
        #1;
        check(upperSetup, 12'h5A3, "upper fields stored");
        host.wrSetup(24'h000C08);
        host.wrExempt(24'hA5C3E1);
        #1;
        check(exemptComparatorSetup, 24'hA5C3E1, "exempt write running");
        check(reconfigWhileRunning, 1'b0, "exempt write not noted");
        host.wrSetup(24'h000E08);
        #1;
        check(setupRdata[9], 1'b1, "start bit held");
        // host leaves the settings alone until the checksum completes
        waitHigh(checksumDoneFlag, 80);
        check(intN, 1'b0, "intN on done");
        check(setupRdata, 24'h000C08, "start bit self-cleared");
        check(checksumResult, crc8({24'hA5C3E1, 24'h000C08}), "checksum value");
        repeat (5) @(posedge clk);
        #1;
        check(checksumDoneFlag, 1'b1, "flag sticky");
        host.clearFlag();
        #1;
        check(intN, 1'b1, "intN released");
        host.wrSetup(24'h000C0A);
        #1;
        check(reconfigWhileRunning, 1'b1, "change while running noted");
        @(posedge clk);
        ce <= 1'b0;
        host.wrSetup(24'h000000);
        ce <= 1'b1;
        #1;
        check(setupRdata, 24'h000C0A, "frozen write ignored");
        host.wrSetup(24'h000E0A);
        host.wrSetup(24'hFFFFFF);
        #1;
        check(setupRdata, 24'h000000, "soft reset clears setup");
        check(softResetPulse, 1'b1, "soft reset pulse");
        check(exemptComparatorSetup, 24'h000000, "soft reset clears exempt");
        repeat (60) @(posedge clk);
        #1;
        check(running, 1'b0, "idle after soft reset");
        check(checksumDoneFlag, 1'b0, "checksum aborted");
        check(checksumBusy, 1'b0, "engine idle");
        summarize();
    end
endmodule
